// [src/sbd_defines.vh]
/*
  Register map, field layout and reset values for the second synthesizer
  divider and pump configuration bank.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
`ifndef SBD_DEFINES_VH
`define SBD_DEFINES_VH

// Offsets are not all multiples of four, so they are word indices.
`define SBD_IDX_CTRL 7'h48
`define SBD_IDX_NDIV_HI 7'h49
`define SBD_IDX_NDIV_LO 7'h4a
`define SBD_IDX_NUM_TOP 7'h4b
`define SBD_IDX_NUM_MID 7'h4c
`define SBD_IDX_NUM_LOW 7'h4d
`define SBD_IDX_DEN_TOP 7'h4e
`define SBD_IDX_DEN_MID 7'h4f
`define SBD_IDX_DEN_LOW 7'h50

`define SBD_CP_MSB 3
`define SBD_CP_LSB 0
`define SBD_DBL_BIT 4
`define SBD_RSV5_BIT 5
`define SBD_NDIV_HI_MSB 3
`define SBD_TOP_MSB 5
`define SBD_BYTE_MSB 7
`define SBD_IDX_MSB 8
`define SBD_IDX_LSB 2
`define SBD_PAD_LSB 9

`define SBD_RST_CP 4'h8
`define SBD_RST_DBL 1'h1
`define SBD_RST_RSV5 1'h0
`define SBD_RST_NDIV_HI 4'h0
`define SBD_RST_NDIV_LO 8'h64
`define SBD_RST_TOP 6'h00
`define SBD_RST_BYTE 8'h00

`define SBD_NDIV_ZERO 12'h000
`define SBD_NDIV_ONE 12'h001
`define SBD_UA_CODE1 13'h0190
`define SBD_UA_CODE2 13'h0320
`define SBD_UA_CODE3 13'h04b0
`define SBD_UA_CODE4 13'h0640
`define SBD_UA_CODE5 13'h07d0
`define SBD_UA_CODE6 13'h0960
`define SBD_UA_CODE7 13'h0af0
`define SBD_UA_CODE8 13'h1900
`define SBD_CP_CODE8 4'h8

`endif

// [src/sbd_config_bank.v]
/*
  APB register bank holding the second synthesizer's doubler enable,
  charge pump current code, integer divider and fractional ratio.
  Assumes pclk at 100 MHz, presetn asynchronous active low, and an APB
  master that holds its request until pready is seen.
*/
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "sbd_defines.vh"

module sbd_config_bank (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Synthesizer configuration
  output wire ref_doubler_enable,
  output wire [3:0] synth_b_pump_current,
  output wire [12:0] synth_b_pump_current_ua,
  output wire [11:0] synth_b_int_divider,
  output wire [11:0] synth_b_divide_ratio,
  output wire [21:0] synth_b_frac_numerator,
  output wire [21:0] synth_b_frac_denominator
);

  reg [3:0] cp_r;
  reg [3:0] cp_nxt;
  reg dbl_r;
  reg dbl_nxt;
  reg rsv5_r;
  reg rsv5_nxt;
  reg [3:0] ndiv_hi_r;
  reg [3:0] ndiv_hi_nxt;
  reg [7:0] ndiv_lo_r;
  reg [7:0] ndiv_lo_nxt;
  reg [5:0] num_top_r;
  reg [5:0] num_top_nxt;
  reg [7:0] num_mid_r;
  reg [7:0] num_mid_nxt;
  reg [7:0] num_low_r;
  reg [7:0] num_low_nxt;
  reg [5:0] den_top_r;
  reg [5:0] den_top_nxt;
  reg [7:0] den_mid_r;
  reg [7:0] den_mid_nxt;
  reg [7:0] den_low_r;
  reg [7:0] den_low_nxt;
  reg [31:0] rdata_nxt;
  reg [31:0] prdata_nxt;

  wire [6:0] idx;
  wire addr_ok;
  wire hit;
  wire setup_phase;
  wire access_phase;
  wire wr_en;

  // Pump current in microamps for a code; unlisted codes give zero.
  function [12:0] pump_ua;
    input [3:0] code;
    begin
      case (code)
        4'h1: begin
          pump_ua = `SBD_UA_CODE1;
        end
        4'h2: begin
          pump_ua = `SBD_UA_CODE2;
        end
        4'h3: begin
          pump_ua = `SBD_UA_CODE3;
        end
        4'h4: begin
          pump_ua = `SBD_UA_CODE4;
        end
        4'h5: begin
          pump_ua = `SBD_UA_CODE5;
        end
        4'h6: begin
          pump_ua = `SBD_UA_CODE6;
        end
        4'h7: begin
          pump_ua = `SBD_UA_CODE7;
        end
        `SBD_CP_CODE8: begin
          pump_ua = `SBD_UA_CODE8;
        end
        default: begin
          pump_ua = 13'h0000;
        end
      endcase
    end
  endfunction

  // Marks the nine word indices that hold a register.
  function idx_mapped;
    input [6:0] index;
    begin
      case (index)
        `SBD_IDX_CTRL, `SBD_IDX_NDIV_HI, `SBD_IDX_NDIV_LO: begin
          idx_mapped = 1'b1;
        end
        `SBD_IDX_NUM_TOP, `SBD_IDX_NUM_MID, `SBD_IDX_NUM_LOW: begin
          idx_mapped = 1'b1;
        end
        `SBD_IDX_DEN_TOP, `SBD_IDX_DEN_MID, `SBD_IDX_DEN_LOW: begin
          idx_mapped = 1'b1;
        end
        default: begin
          idx_mapped = 1'b0;
        end
      endcase
    end
  endfunction

  // Places an eight-bit register in the low byte of a read word.
  function [31:0] byte_word;
    input [7:0] value;
    begin
      byte_word = 32'h00000000;
      byte_word[`SBD_BYTE_MSB:0] = value;
    end
  endfunction

  // Reserved bits above a six-bit field always read back as zero.
  function [31:0] top_word;
    input [5:0] value;
    begin
      top_word = 32'h00000000;
      top_word[`SBD_TOP_MSB:0] = value;
    end
  endfunction

  // A programmed divider of zero behaves as a divide by one.
  function [11:0] divide_ratio;
    input [11:0] value;
    begin
      if (value == `SBD_NDIV_ZERO) begin
        divide_ratio = `SBD_NDIV_ONE;
      end else begin
        divide_ratio = value;
      end
    end
  endfunction

  // A misaligned or out-of-range address is refused and never writes.
  assign idx = paddr[`SBD_IDX_MSB:`SBD_IDX_LSB];
  assign addr_ok = (paddr[31:`SBD_PAD_LSB] == 23'h000000) &&
    (paddr[1:0] == 2'h0);
  assign hit = addr_ok & idx_mapped(idx);
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign pready = 1'b1;
  assign pslverr = access_phase & ~hit;
  assign wr_en = access_phase & pwrite & hit & pstrb[0];

  // Read word for the addressed register.
  always @* begin
    rdata_nxt = 32'h00000000;
    case (idx)
      `SBD_IDX_CTRL: begin
        rdata_nxt[`SBD_CP_MSB:`SBD_CP_LSB] = cp_r;
        rdata_nxt[`SBD_DBL_BIT] = dbl_r;
        rdata_nxt[`SBD_RSV5_BIT] = rsv5_r;
      end
      `SBD_IDX_NDIV_HI: begin
        rdata_nxt[`SBD_NDIV_HI_MSB:0] = ndiv_hi_r;
      end
      `SBD_IDX_NDIV_LO: begin
        rdata_nxt = byte_word(ndiv_lo_r);
      end
      `SBD_IDX_NUM_TOP: begin
        rdata_nxt = top_word(num_top_r);
      end
      `SBD_IDX_NUM_MID: begin
        rdata_nxt = byte_word(num_mid_r);
      end
      `SBD_IDX_NUM_LOW: begin
        rdata_nxt = byte_word(num_low_r);
      end
      `SBD_IDX_DEN_TOP: begin
        rdata_nxt = top_word(den_top_r);
      end
      `SBD_IDX_DEN_MID: begin
        rdata_nxt = byte_word(den_mid_r);
      end
      `SBD_IDX_DEN_LOW: begin
        rdata_nxt = byte_word(den_low_r);
      end
      default: begin
        rdata_nxt = 32'h00000000;
      end
    endcase
  end

  // Read data is captured in the setup cycle so it is stable in the access.
  always @* begin
    prdata_nxt = prdata;
    if (setup_phase && !pwrite && hit) begin
      prdata_nxt = rdata_nxt;
    end else if (setup_phase) begin
      prdata_nxt = 32'h00000000;
    end
  end

  // A write changes only the defined bits of the addressed register.
  always @* begin
    cp_nxt = cp_r;
    dbl_nxt = dbl_r;
    rsv5_nxt = rsv5_r;
    ndiv_hi_nxt = ndiv_hi_r;
    ndiv_lo_nxt = ndiv_lo_r;
    num_top_nxt = num_top_r;
    num_mid_nxt = num_mid_r;
    num_low_nxt = num_low_r;
    den_top_nxt = den_top_r;
    den_mid_nxt = den_mid_r;
    den_low_nxt = den_low_r;
    if (wr_en) begin
      case (idx)
        `SBD_IDX_CTRL: begin
          cp_nxt = pwdata[`SBD_CP_MSB:`SBD_CP_LSB];
          dbl_nxt = pwdata[`SBD_DBL_BIT];
          rsv5_nxt = pwdata[`SBD_RSV5_BIT];
        end
        `SBD_IDX_NDIV_HI: begin
          ndiv_hi_nxt = pwdata[`SBD_NDIV_HI_MSB:0];
        end
        `SBD_IDX_NDIV_LO: begin
          ndiv_lo_nxt = pwdata[`SBD_BYTE_MSB:0];
        end
        `SBD_IDX_NUM_TOP: begin
          num_top_nxt = pwdata[`SBD_TOP_MSB:0];
        end
        `SBD_IDX_NUM_MID: begin
          num_mid_nxt = pwdata[`SBD_BYTE_MSB:0];
        end
        `SBD_IDX_NUM_LOW: begin
          num_low_nxt = pwdata[`SBD_BYTE_MSB:0];
        end
        `SBD_IDX_DEN_TOP: begin
          den_top_nxt = pwdata[`SBD_TOP_MSB:0];
        end
        `SBD_IDX_DEN_MID: begin
          den_mid_nxt = pwdata[`SBD_BYTE_MSB:0];
        end
        `SBD_IDX_DEN_LOW: begin
          den_low_nxt = pwdata[`SBD_BYTE_MSB:0];
        end
        default: begin
          cp_nxt = cp_r;
        end
      endcase
    end
  end

  // Every register loads its next value on each clock edge.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      cp_r <= `SBD_RST_CP;
      dbl_r <= `SBD_RST_DBL;
      rsv5_r <= `SBD_RST_RSV5;
      ndiv_hi_r <= `SBD_RST_NDIV_HI;
      ndiv_lo_r <= `SBD_RST_NDIV_LO;
      num_top_r <= `SBD_RST_TOP;
      num_mid_r <= `SBD_RST_BYTE;
      num_low_r <= `SBD_RST_BYTE;
      den_top_r <= `SBD_RST_TOP;
      den_mid_r <= `SBD_RST_BYTE;
      den_low_r <= `SBD_RST_BYTE;
    end else begin
      prdata <= prdata_nxt;
      cp_r <= cp_nxt;
      dbl_r <= dbl_nxt;
      rsv5_r <= rsv5_nxt;
      ndiv_hi_r <= ndiv_hi_nxt;
      ndiv_lo_r <= ndiv_lo_nxt;
      num_top_r <= num_top_nxt;
      num_mid_r <= num_mid_nxt;
      num_low_r <= num_low_nxt;
      den_top_r <= den_top_nxt;
      den_mid_r <= den_mid_nxt;
      den_low_r <= den_low_nxt;
    end
  end

  assign ref_doubler_enable = dbl_r;
  assign synth_b_pump_current = cp_r;
  assign synth_b_pump_current_ua = pump_ua(cp_r);
  assign synth_b_int_divider = {ndiv_hi_r, ndiv_lo_r};
  assign synth_b_divide_ratio = divide_ratio(synth_b_int_divider);
  assign synth_b_frac_numerator = {num_top_r, num_mid_r, num_low_r};
  assign synth_b_frac_denominator = {den_top_r, den_mid_r, den_low_r};

endmodule
`default_nettype wire

// [test/sbd_config_bank_sva.sv]
/* Checker on the bank ports.
   Bound to every bank instance below. */
`timescale 1ns/1ps
`default_nettype none
module sbd_chk (
  // Bus and settings
  input wire pclk, presetn, psel, penable, pwrite, pslverr,
  input wire [31:0] paddr, pwdata,
  input wire [3:0] pstrb, synth_b_pump_current,
  input wire ref_doubler_enable,
  input wire [12:0] synth_b_pump_current_ua,
  input wire [11:0] synth_b_int_divider, synth_b_divide_ratio
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite && pstrb[0];
  wire [3:0] cp = synth_b_pump_current;
  wire [11:0] nd = synth_b_int_divider;
  dbl_write_a: assert property (wr && paddr == 32'h120 |=>
    ref_doubler_enable == $past(pwdata[4])) else $error("doubler");
  pump_write_a: assert property (wr && paddr == 32'h120 |=>
    cp == $past(pwdata[3:0])) else $error("pump");
  pump_ua_a: assert property (synth_b_pump_current_ua == (cp == 4'h8 ?
    13'h1900 : cp && cp < 4'h8 ? 13'h0190 * cp : 13'h0)) else $error("ua");
  ratio_a: assert property (synth_b_divide_ratio ==
    (nd ? nd : 12'h001)) else $error("ratio");
  div_hi_a: assert property (wr && paddr == 32'h124 |=>
    nd[11:8] == $past(pwdata[3:0])) else $error("high");
  div_lo_a: assert property (wr && paddr == 32'h128 |=>
    nd[7:0] == $past(pwdata[7:0])) else $error("low");
  bad_addr_a: assert property (psel && penable && paddr == 32'h144
    |-> pslverr) else $error("no error");
  reset_val_a: assert property ($rose(presetn) |->
    ref_doubler_enable && cp == 4'h8 && nd == 12'h064) else $error("reset");
  cover property (wr && paddr == 32'h120);
  cover property (nd == 12'h000);
  cover property (pslverr);
endmodule
bind sbd_config_bank sbd_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .pslverr, .paddr, .pwdata, .pstrb, .synth_b_pump_current,
  .ref_doubler_enable, .synth_b_pump_current_ua, .synth_b_int_divider,
  .synth_b_divide_ratio);
`default_nettype wire

// [test/tb_top.sv]
/* Bench for the bank.
   Drives the APB port itself. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 0, cp;
  logic pready, pslverr, err, dbl;
  logic [12:0] ua;
  logic [11:0] nd, ratio;
  logic [21:0] num, den;
  int fails = 0, checked = 0;
  sbd_config_bank dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .pslverr, .prdata, .ref_doubler_enable(dbl),
    .synth_b_pump_current(cp), .synth_b_pump_current_ua(ua),
    .synth_b_int_divider(nd), .synth_b_divide_ratio(ratio),
    .synth_b_frac_numerator(num), .synth_b_frac_denominator(den));
  initial forever #5 pclk = ~pclk;
  task automatic chk(string s, logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic bus(bit w, logic [6:0] i, logic [31:0] d,
    logic [3:0] s = 4'hf);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, 23'h0, i, 2'h0, d, s};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 0;
    @(posedge pclk);
  endtask
  task automatic t_reset;
    logic [7:0] e [9] = '{8'h18, 0, 8'h64, 0, 0, 0, 0, 0, 0};
    for (int k = 0; k < 9; k++) begin
      bus(0, 7'(72 + k), 0);
      chk("reset", rd, e[k]);
    end
    $display("reset done");
  endtask
  task automatic t_pump;
    logic [31:0] v;
    for (int c = 0; c < 16; c++) begin
      v = 32'(c) | 32'(c % 2) << 4;
      bus(1, 7'h48, v | 32'hffffffc0);
      chk("ua", ua, c == 8 ? 6400 : c && c < 8 ? 400 * c : 0);
      chk("doubler", dbl, c % 2);
      bus(0, 7'h48, 0);
      chk("ctrl", rd, v);
    end
    $display("pump done");
  endtask
  task automatic t_div;
    logic [27:0] t [4] = '{28'hff00f00, 28'h1, 28'h1001, 28'hfffffff};
    foreach (t[k]) begin
      bus(1, 7'h49, t[k][27:20]);
      bus(1, 7'h4a, t[k][19:12]);
      chk("divider", nd, {t[k][23:20], t[k][19:12]});
      chk("ratio", ratio, t[k][11:0]);
    end
    $display("divider done");
  endtask
  task automatic t_frac;
    logic [7:0] v [6] = '{8'hff, 8'ha5, 8'h3c, 8'hc1, 8'h5a, 8'h96};
    foreach (v[k]) bus(1, 7'(75 + k), v[k]);
    chk("num", num, 22'h3fa53c);
    chk("den", den, 22'h15a96);
    bus(0, 7'h4b, 0);
    chk("num top", rd, 8'h3f);
    chk("mapped", err, 0);
    bus(0, 7'h4e, 0);
    chk("den top", rd, 8'h01);
    bus(1, 7'h51, 8'hff);
    chk("unmapped", err, 1);
    bus(1, 7'h48, 0, 4'h0);
    chk("strobe", cp, 4'hf);
    $display("frac done");
  endtask
  task give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_pump;
    t_div;
    t_frac;
    give_verdict;
  end
  initial begin
    #20us;
    fails++;
    give_verdict;
  end
endmodule
`default_nettype wire
